// file: bench/rtcc_chk.sv
// Checker of the counter chain register port and interrupt line.
// Bound to rtcc_top; sees only its ports.
`timescale 1ns/100ps
module rtcc_chk (
  // Clock and resets
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_wdt_ext_reset,
  // Register port and interrupt
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_we,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic i_irq_ack,
  input wire logic o_irq_pending
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset || i_wdt_ext_reset);
  // Write to an address, then read it back on the next cycle
  sequence wr_then_rd(a);
    i_sfr_we && i_sfr_addr == a ##1 !i_sfr_we && i_sfr_addr == a;
  endsequence
  sequence cfg_off;
    i_sfr_we && i_sfr_addr == 8'ha1 && i_sfr_wdata[2:1] == 2'h0
      ##1 !i_sfr_we && i_sfr_addr == 8'ha1;
  endsequence
  a_por_clear: assert property (disable iff (i_wdt_ext_reset)
    i_reset |=> o_sfr_rdata == 8'h00 && !o_irq_pending) else $error("por");
  a_cfg_reset: assert property (disable iff (i_wdt_ext_reset)
    i_reset ##1 !i_reset && !i_sfr_we && i_sfr_addr == 8'ha1
    |=> o_sfr_rdata == 8'h01) else $error("config reset value");
  a_irq_hold: assert property (o_irq_pending && !i_irq_ack
    |=> o_irq_pending) else $error("interrupt dropped");
  a_ack_clear: assert property (i_irq_ack
    |=> !o_irq_pending) else $error("interrupt not cleared");
  a_target_rb: assert property (wr_then_rd(8'ha6)
    |=> o_sfr_rdata == $past(i_sfr_wdata, 2)) else $error("target");
  a_cfg_rb: assert property (wr_then_rd(8'ha1)
    |=> o_sfr_rdata[6:3] == $past(i_sfr_wdata[6:3], 2)
    && o_sfr_rdata[0] == $past(i_sfr_wdata[0], 2)) else $error("config");
  a_alarm_off: assert property (cfg_off
    |=> o_sfr_rdata[2:1] == 2'h0) else $error("alarm or enable stuck");
  a_keyed_rb: assert property (i_sfr_we && i_sfr_addr == 8'hc1
    && i_sfr_wdata == 8'hea ##2 wr_then_rd(8'ha3)
    |=> o_sfr_rdata == $past(i_sfr_wdata, 2)) else $error("keyed write");
endmodule
bind rtcc_top rtcc_chk rtcc_chk_inst (.i_clk_sys, .i_reset,
  .i_wdt_ext_reset, .i_sfr_addr, .i_sfr_wdata, .i_sfr_we, .o_sfr_rdata,
  .i_irq_ack, .o_irq_pending);

// file: bench/rtcc_cpu.sv
// Processor core model: drives the register port, acknowledges the
// interrupt. Assumes the system clock is shared with the block.
`timescale 1ns/100ps
module rtcc_cpu (
  // Clock
  input wire logic i_clk_sys,
  // Register port
  output logic [7:0] o_sfr_addr,
  output logic [7:0] o_sfr_wdata,
  output logic o_sfr_we,
  input wire logic [7:0] i_sfr_rdata,
  // Interrupt acknowledge
  output logic o_irq_ack
);
  // Idle port at time zero
  initial begin
    o_sfr_addr = 8'ha1;
    o_sfr_wdata = 8'h00;
    o_sfr_we = 1'b0;
    o_irq_ack = 1'b0;
  end
  // One write, held over one sampling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    o_sfr_addr <= a;
    o_sfr_wdata <= d;
    o_sfr_we <= 1'b1;
    @(posedge i_clk_sys);
    o_sfr_we <= 1'b0;
  endtask
  // Counter write between unlock and relock
  task automatic wr_keyed(input logic [7:0] a, input logic [7:0] d);
    wr(8'hc1, 8'hea);
    wr(a, d);
    wr(8'hc1, 8'h00);
  endtask
  // Config writes keep the reserved bit set
  task automatic wr_cfg(input logic [7:0] d);
    wr(8'ha1, d | 8'h01);
  endtask
  // Read: address taken at one edge, data shown just after it
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    o_sfr_addr <= a;
    @(posedge i_clk_sys);
    #1 d = i_sfr_rdata;
  endtask
  // One-cycle acknowledge pulse
  task automatic ack;
    @(posedge i_clk_sys);
    o_irq_ack <= 1'b1;
    @(posedge i_clk_sys);
    o_irq_ack <= 1'b0;
  endtask
endmodule

// file: bench/tb.sv
// Testbench: reset values, time cascade, interval alarm in all time
// bases, reset retention. Crystal runs fast to keep the run short.
`timescale 1ns/100ps
module tb;
  logic i_clk_sys, i_reset, i_wdt_ext_reset, i_clk32k;
  logic [7:0] addr, wdata, rdata, v;
  logic we, ack, irq;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  rtcc_top rtcc_top_inst (.i_clk_sys, .i_reset, .i_wdt_ext_reset,
    .i_clk32k, .i_sfr_addr(addr), .i_sfr_wdata(wdata), .i_sfr_we(we),
    .o_sfr_rdata(rdata), .i_irq_ack(ack), .o_irq_pending(irq));
  rtcc_cpu rtcc_cpu_inst (.i_clk_sys, .o_sfr_addr(addr),
    .o_sfr_wdata(wdata), .o_sfr_we(we), .i_sfr_rdata(rdata),
    .o_irq_ack(ack));
  // Clocks: 10 MHz system, crystal at 1/4 of it
  always #50 i_clk_sys = ~i_clk_sys;
  always #200 i_clk32k = ~i_clk32k;
  // Hang guard
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
    rtcc_cpu_inst.rd(a, v);
    chk(v, exp);
  endtask
  task automatic chk_irq(input logic exp);
    #1;
    n_tests++;
    if (irq !== exp) begin
      mismatches++;
      $display("mismatch at %0t: interrupt %b", $time, irq);
    end
  endtask
  // Bounded wait for the interrupt line
  task automatic wait_irq(input int n);
    for (int i = 0; i < n && irq !== 1'b1; i++) begin
      @(posedge i_clk_sys);
      #1;
    end
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk_rd(8'ha1, 8'h01);
    for (int a = 'ha2; a < 'ha7; a++) chk_rd(8'(a), 8'h00);
    chk_rd(8'h50, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_cascade;
    rtcc_cpu_inst.wr_cfg(8'h40);
    rtcc_cpu_inst.wr_keyed(8'ha5, 8'h17);
    rtcc_cpu_inst.wr_keyed(8'ha4, 8'h3b);
    rtcc_cpu_inst.wr_keyed(8'ha3, 8'h3b);
    rtcc_cpu_inst.wr_keyed(8'ha2, 8'h7f);
    wait_irq(1100);
    chk_irq(1'b1);
    for (int a = 'ha2; a < 'ha6; a++) chk_rd(8'(a), 8'h00);
    chk_rd(8'ha1, 8'hc1);
    rtcc_cpu_inst.ack();
    chk_irq(1'b0);
    rtcc_cpu_inst.wr_cfg(8'h40);
    chk_rd(8'ha1, 8'h41);
    rtcc_cpu_inst.wr(8'ha3, 8'h12);
    chk_rd(8'ha3, 8'h00);
    $display("test cascade done");
  endtask
  task automatic t_periodic;
    rtcc_cpu_inst.wr(8'ha6, 8'h02);
    chk_rd(8'ha6, 8'h02);
    rtcc_cpu_inst.wr_cfg(8'h02);
    wait_irq(2200);
    chk_irq(1'b1);
    chk_rd(8'ha1, 8'h07);
    rtcc_cpu_inst.ack();
    rtcc_cpu_inst.wr_cfg(8'h02);
    chk_rd(8'ha1, 8'h03);
    rtcc_cpu_inst.wr_cfg(8'h06);
    chk_rd(8'ha1, 8'h03);
    wait_irq(2200);
    chk_irq(1'b1);
    rtcc_cpu_inst.ack();
    $display("test periodic done");
  endtask
  task automatic t_bases;
    for (int b = 0; b < 4; b++) begin
      rtcc_cpu_inst.wr_cfg(8'h00);
      chk_rd(8'ha1, 8'h01);
      rtcc_cpu_inst.wr(8'ha6, 8'h01);
      rtcc_cpu_inst.wr_cfg({2'h0, 2'(b), 4'ha});
      // Second pass primes the same carry again: a single shot must stay
      for (int k = 0; k < 2; k++) begin
        if (b > 2) rtcc_cpu_inst.wr_keyed(8'ha4, 8'h3b);
        if (b > 1) rtcc_cpu_inst.wr_keyed(8'ha3, 8'h3b);
        if (b > 0) rtcc_cpu_inst.wr_keyed(8'ha2, 8'h7f);
        wait_irq(1100);
        if (k == 0) begin
          chk_irq(1'b1);
          rtcc_cpu_inst.ack();
          rtcc_cpu_inst.wr_cfg({2'h0, 2'(b), 4'ha});
        end else begin
          chk_irq(1'b0);
        end
      end
    end
    $display("test bases done");
  endtask
  task automatic t_resets;
    rtcc_cpu_inst.wr(8'hc1, 8'hea);
    rtcc_cpu_inst.wr(8'ha3, 8'h21);
    chk_rd(8'ha3, 8'h21);
    rtcc_cpu_inst.wr(8'hc1, 8'h00);
    @(posedge i_clk_sys) i_wdt_ext_reset <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    i_wdt_ext_reset <= 1'b0;
    chk_rd(8'ha3, 8'h21);
    chk_rd(8'ha1, 8'h01);
    @(posedge i_clk_sys) i_reset <= 1'b1;
    repeat (6) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    chk_rd(8'ha3, 8'h00);
    $display("test resets done");
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    i_clk_sys = 1'b0;
    i_reset = 1'b1;
    i_wdt_ext_reset = 1'b0;
    i_clk32k = 1'b0;
    repeat (6) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    t_reset();
    t_cascade();
    t_periodic();
    t_bases();
    t_resets();
    finish_test();
  end
endmodule

// file: hdl/rtcc_pkg.sv
// Constants for the real-time clock counter chain: register addresses,
// field positions, reset values and the tick prescale.
// Assumes an 8-bit special function register port from the processor core.

package rtcc_pkg;

  // Register addresses
  localparam logic [7:0] ADDR_CONFIG = 8'ha1;
  localparam logic [7:0] ADDR_FRAC = 8'ha2;
  localparam logic [7:0] ADDR_SEC = 8'ha3;
  localparam logic [7:0] ADDR_MIN = 8'ha4;
  localparam logic [7:0] ADDR_HOUR = 8'ha5;
  localparam logic [7:0] ADDR_TARGET = 8'ha6;
  localparam logic [7:0] ADDR_KEY = 8'hc1;

  // Configuration field positions
  localparam int BIT_ROLLOVER = 7;
  localparam int BIT_DAY_LEN = 6;
  localparam int BIT_BASE_HI = 5;
  localparam int BIT_BASE_LO = 4;
  localparam int BIT_SINGLE = 3;
  localparam int BIT_ALARM = 2;
  localparam int BIT_ENABLE = 1;
  localparam int BIT_RSVD = 0;

  // Reset values and key
  localparam logic [7:0] CONFIG_RESET = 8'h01;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] UNLOCK_KEY = 8'hea;

  // Time base encodings
  localparam logic [1:0] BASE_FRAC = 2'h0;
  localparam logic [1:0] BASE_SEC = 2'h1;
  localparam logic [1:0] BASE_MIN = 2'h2;
  localparam logic [1:0] BASE_HOUR = 2'h3;

  // Counter wrap points
  localparam logic [7:0] FRAC_TOP = 8'h7f;
  localparam logic [7:0] SEXA_TOP = 8'h3b;
  localparam logic [7:0] HOUR_TOP_24 = 8'h17;
  localparam logic [7:0] HOUR_TOP_256 = 8'hff;

  // Tick prescale from the calibrated crystal
  localparam int CRYSTAL_HZ = 32768;
  localparam int TICK_HZ = 128;
  localparam int PRESCALE = CRYSTAL_HZ / TICK_HZ;
  localparam logic [7:0] PRESCALE_LAST = 8'(PRESCALE - 1);

endpackage

// file: hdl/rtcc_tick_gen.sv
// Tick generator: synchronises the 32.768 kHz crystal clock and divides
// its rising edges down to a one-cycle 1/128 second tick.
// Assumes the system clock is well above twice the crystal rate.
`timescale 1ns/100ps

module rtcc_tick_gen (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Crystal clock pin
  input wire logic i_clk32k,
  // Tick out
  output logic o_tick
);

  logic sync1_q, sync2_q, sync3_q, level_q, level_d;
  logic [7:0] div_q, div_d;
  logic tick_d;

  //////////////////////////////////////////////////////////////////////////
  // Edge detect on the agreed level, then divide
  always_comb begin
    level_d = level_q;
    div_d = div_q;
    tick_d = 1'b0;
    if (sync2_q == sync3_q && sync3_q != level_q) begin
      level_d = sync3_q;
      if (sync3_q) begin
        if (div_q == rtcc_pkg::PRESCALE_LAST) begin
          div_d = 8'h00;
          tick_d = 1'b1;
        end else begin
          div_d = div_q + 8'h01;
        end
      end
    end
  end

  // Three-stage synchroniser and registers
  always_ff @(posedge i_clk_sys) begin
    sync1_q <= i_clk32k;
    sync2_q <= sync1_q;
    sync3_q <= sync2_q;
    if (i_reset) begin
      level_q <= 1'b0;
      div_q <= 8'h00;
      o_tick <= 1'b0;
    end else begin
      level_q <= level_d;
      div_q <= div_d;
      o_tick <= tick_d;
    end
  end

endmodule

// file: hdl/rtcc_top.sv
// Real-time clock counter chain with interval alarm timer, reached over
// the processor's special function register port.
// Assumes i_reset is power-on reset and i_wdt_ext_reset the watchdog or
// external reset; both synchronous to i_clk_sys.
`timescale 1ns/100ps

module rtcc_top (
  // Clock and resets
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_wdt_ext_reset,
  // Crystal clock pin
  input wire logic i_clk32k,
  // Register port
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_we,
  output logic [7:0] o_sfr_rdata,
  // Interrupt request handshake
  input wire logic i_irq_ack,
  output logic o_irq_pending
);

  logic tick;
  logic [7:0] frac_q, frac_d, sec_q, sec_d, min_q, min_d, hour_q, hour_d;
  logic [7:0] cfg_q, cfg_d, target_q, target_d, key_q, key_d;
  logic [7:0] ivcnt_q, ivcnt_d, ivinc;
  logic done_q, done_d, irq_d;
  logic [7:0] rdata_d;
  logic [8:0] frac_n, sec_n, min_n, hour_n;
  logic sec_tick, min_tick, hour_tick, day_wrap, iv_tick, alarm_set;
  logic unlocked, wr_cfg;

  // Increment with wrap: bit 8 flags the wrap
  function automatic logic [8:0] wrap_inc(input logic [7:0] v,
                                          input logic [7:0] top);
    if (v >= top)
      wrap_inc = {1'b1, rtcc_pkg::COUNT_RESET};
    else
      wrap_inc = {1'b0, v + 8'h01};
  endfunction

  // Write strobe for one register address
  function automatic logic sfr_write(input logic we,
                                     input logic [7:0] addr,
                                     input logic [7:0] reg_addr);
    sfr_write = we && addr == reg_addr;
  endfunction

  // Calibrated 1/128 s tick, already in the system clock domain
  rtcc_tick_gen u_tick (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_clk32k(i_clk32k),
    .o_tick(tick)
  );

  //////////////////////////////////////////////////////////////////////////
  // Cascade of timekeeping carries; every carry ripples within the one
  // tick cycle, so software never reads a half-updated time
  always_comb begin
    frac_n = wrap_inc(frac_q, rtcc_pkg::FRAC_TOP);
    sec_n = wrap_inc(sec_q, rtcc_pkg::SEXA_TOP);
    min_n = wrap_inc(min_q, rtcc_pkg::SEXA_TOP);
    hour_n = wrap_inc(hour_q, cfg_q[rtcc_pkg::BIT_DAY_LEN] ?
                      rtcc_pkg::HOUR_TOP_24 : rtcc_pkg::HOUR_TOP_256);
    sec_tick = tick & frac_n[8];
    min_tick = sec_tick & sec_n[8];
    hour_tick = min_tick & min_n[8];
    day_wrap = hour_tick & hour_n[8];
    unlocked = key_q == rtcc_pkg::UNLOCK_KEY;
    wr_cfg = sfr_write(i_sfr_we, i_sfr_addr, rtcc_pkg::ADDR_CONFIG);
  end

  // Timekeeping counters: a keyed write wins over the tick
  always_comb begin
    frac_d = tick ? frac_n[7:0] : frac_q;
    sec_d = sec_tick ? sec_n[7:0] : sec_q;
    min_d = min_tick ? min_n[7:0] : min_q;
    hour_d = hour_tick ? hour_n[7:0] : hour_q;
    // Without the key in place a counter write is dropped
    if (i_sfr_we && unlocked) begin
      unique case (i_sfr_addr)
        rtcc_pkg::ADDR_FRAC: frac_d = i_sfr_wdata;
        rtcc_pkg::ADDR_SEC: sec_d = i_sfr_wdata;
        rtcc_pkg::ADDR_MIN: min_d = i_sfr_wdata;
        rtcc_pkg::ADDR_HOUR: hour_d = i_sfr_wdata;
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Interval timer on the selected time base
  always_comb begin
    unique case (cfg_q[rtcc_pkg::BIT_BASE_HI:rtcc_pkg::BIT_BASE_LO])
      rtcc_pkg::BASE_FRAC: iv_tick = tick;
      rtcc_pkg::BASE_SEC: iv_tick = sec_tick;
      rtcc_pkg::BASE_MIN: iv_tick = min_tick;
      rtcc_pkg::BASE_HOUR: iv_tick = hour_tick;
    endcase
    ivinc = ivcnt_q + 8'h01;
    ivcnt_d = ivcnt_q;
    done_d = done_q;
    alarm_set = 1'b0;
    if (!cfg_q[rtcc_pkg::BIT_ENABLE]) begin
      ivcnt_d = rtcc_pkg::COUNT_RESET;
      done_d = 1'b0;
    end else if (iv_tick && !done_q) begin
      // A single shot parks the count at the target; only clearing the
      // enable re-arms it
      ivcnt_d = ivinc;
      if (ivinc == target_q) begin
        alarm_set = 1'b1;
        if (cfg_q[rtcc_pkg::BIT_SINGLE])
          done_d = 1'b1;
        else
          ivcnt_d = rtcc_pkg::COUNT_RESET;
      end
    end
  end

  // Configuration, key and target registers; flags set over clear
  always_comb begin
    cfg_d = cfg_q;
    target_d = target_q;
    key_d = key_q;
    if (wr_cfg) begin
      cfg_d = i_sfr_wdata;
      cfg_d[rtcc_pkg::BIT_ROLLOVER] = cfg_q[rtcc_pkg::BIT_ROLLOVER] &
                                      i_sfr_wdata[rtcc_pkg::BIT_ROLLOVER];
      cfg_d[rtcc_pkg::BIT_ALARM] = cfg_q[rtcc_pkg::BIT_ALARM] &
                                   i_sfr_wdata[rtcc_pkg::BIT_ALARM];
    end
    if (alarm_set)
      cfg_d[rtcc_pkg::BIT_ALARM] = 1'b1;
    if (day_wrap)
      cfg_d[rtcc_pkg::BIT_ROLLOVER] = 1'b1;
    if (sfr_write(i_sfr_we, i_sfr_addr, rtcc_pkg::ADDR_TARGET))
      target_d = i_sfr_wdata;
    // Any value other than the key locks the counters again
    if (sfr_write(i_sfr_we, i_sfr_addr, rtcc_pkg::ADDR_KEY))
      key_d = i_sfr_wdata;
    // A new event wins over an acknowledge in the same cycle, so no
    // alarm or rollover is lost
    irq_d = alarm_set | day_wrap | (o_irq_pending & ~i_irq_ack);
  end

  // Read multiplexer; unmapped addresses read zero
  // The key reads back, so software can see whether it left it open
  always_comb begin
    unique case (i_sfr_addr)
      rtcc_pkg::ADDR_CONFIG: rdata_d = cfg_q;
      rtcc_pkg::ADDR_FRAC: rdata_d = frac_q;
      rtcc_pkg::ADDR_SEC: rdata_d = sec_q;
      rtcc_pkg::ADDR_MIN: rdata_d = min_q;
      rtcc_pkg::ADDR_HOUR: rdata_d = hour_q;
      rtcc_pkg::ADDR_TARGET: rdata_d = target_q;
      rtcc_pkg::ADDR_KEY: rdata_d = key_q;
      default: rdata_d = 8'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Timekeeping registers: only the power-on reset clears them, so the
  // time of day rides through a watchdog or external reset
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      frac_q <= rtcc_pkg::COUNT_RESET;
      sec_q <= rtcc_pkg::COUNT_RESET;
      min_q <= rtcc_pkg::COUNT_RESET;
      hour_q <= rtcc_pkg::COUNT_RESET;
    end else begin
      frac_q <= frac_d;
      sec_q <= sec_d;
      min_q <= min_d;
      hour_q <= hour_d;
    end
  end

  // Configuration register: a soft reset keeps the day length so the
  // hours keep wrapping where software last asked them to
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      cfg_q <= rtcc_pkg::CONFIG_RESET;
    end else if (i_wdt_ext_reset) begin
      cfg_q <= rtcc_pkg::CONFIG_RESET;
      cfg_q[rtcc_pkg::BIT_DAY_LEN] <= cfg_q[rtcc_pkg::BIT_DAY_LEN];
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // Interval counter, key and target: any reset stops the alarm and
  // relocks the counters
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || i_wdt_ext_reset) begin
      target_q <= rtcc_pkg::COUNT_RESET;
      key_q <= rtcc_pkg::COUNT_RESET;
      ivcnt_q <= rtcc_pkg::COUNT_RESET;
      done_q <= 1'b0;
    end else begin
      target_q <= target_d;
      key_q <= key_d;
      ivcnt_q <= ivcnt_d;
      done_q <= done_d;
    end
  end

  // Port outputs come straight from flip-flops; read data trails the
  // address by one cycle
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || i_wdt_ext_reset) begin
      o_irq_pending <= 1'b0;
      o_sfr_rdata <= 8'h00;
    end else begin
      o_irq_pending <= irq_d;
      o_sfr_rdata <= rdata_d;
    end
  end

endmodule
